// ==== spi_frame_consts.vh ====
// Purpose: Constants for the serial frame slave.
// Assumes: 16-bit frames, fixed widths.
// Notes:   Definitions only.
`ifndef SPI_FRAME_CONSTS_VH
`define SPI_FRAME_CONSTS_VH
`define FRAME_BITS      16
`define FRAME_BITS_CNT  5'h10
`define CNT_WIDTH       5
`define CNT_MAX         5'h1F
`define ADDR_LSB        0
`define ADDR_MSB        6
`define WRITE_BIT       7
`define DATA_LSB        8
`define DATA_MSB        15
`define SYNC_RESET      1'b0
`define SEL_RESET       1'b1
`define FAULT_RESET     1'b0
`define BUF_DEPTH       2
`endif

// ==== spi_frame_slave.v ====
// Purpose: Serial slave that takes 16-bit frames and shifts out a response word.
// Assumes: Pins are asynchronous to ref_clk and oversampled; serial clock at most ref_clk/8.
// Notes:   Bits travel LSB first; received frames leave through a two-entry buffer.
`timescale 1ns/100ps
`default_nettype none
`include "spi_frame_consts.vh"

module spi_frame_slave (
  input  wire        ref_clk,           // System clock, 125 MHz
  input  wire        reset,             // Synchronous reset, active high
  input  wire        select_active_low, // Chip select pin, active low
  input  wire        serialClk,         // Serial clock pin from host
  input  wire        serial_in_line,    // Serial data pin from host
  output reg         serial_out_line,   // Serial data to host
  output reg         serialOutEnable,   // High while the device drives the output pin
  input  wire        restartMode,       // High while the device is in restart mode
  input  wire [15:0] responseWord,      // Word sent in the next frame, sampled at select fall
  output wire        frameValid,        // Buffered frame available
  input  wire        frameReady,        // Consumer takes the frame
  output wire [6:0]  frameAddr,         // Register address of the frame
  output wire        frameWrite,        // Write / read-and-clear selector
  output wire [7:0]  frameData,         // Data byte of the frame
  output wire        faultPending       // Fault awaiting report in the next frame
);

  reg       selPrevReg;
  reg       clkPrevReg;
  reg [`CNT_WIDTH-1:0] countReg;
  reg [15:0] inShiftReg;
  reg [15:0] outShiftReg;
  reg        faultReg;
  reg [15:0] bufMem [0:`BUF_DEPTH-1];
  reg        wrPtrReg;
  reg        rdPtrReg;
  reg [1:0]  fillReg;

  wire selSync;
  wire clkSync;
  wire dinSync;
  wire selFall  = selPrevReg & ~selSync;
  wire selRise  = ~selPrevReg & selSync;
  wire active   = ~selSync & ~selPrevReg;
  wire clkRise  = active & clkSync & ~clkPrevReg;
  wire clkFall  = active & ~clkSync & clkPrevReg;
  wire bufFull  = (fillReg == 2'h2);
  wire bufPush;
  wire bufPop   = frameValid & frameReady;
  wire countBad = (countReg != 5'h00) & (countReg != `FRAME_BITS_CNT);
  wire clkHighEdge = (selFall | selRise) & clkSync;
  wire frameBad = countBad | clkHighEdge | restartMode | bufFull;
  wire frameGood = selRise & (countReg == `FRAME_BITS_CNT) & ~frameBad;

  // Restart mode and overrun drop the frame too, so the host sees the loss
  assign bufPush = frameGood;
  assign faultPending = faultReg;
  assign frameValid = (fillReg != 2'h0);
  assign frameAddr  = bufMem[rdPtrReg][`ADDR_MSB:`ADDR_LSB];
  assign frameWrite = bufMem[rdPtrReg][`WRITE_BIT];
  assign frameData  = bufMem[rdPtrReg][`DATA_MSB:`DATA_LSB];

  // Each pin crosses into ref_clk through its own two flip-flops
  pin_sync #(
    .RESET_LEVEL (`SEL_RESET)
  ) selSyncInst (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pinIn   (select_active_low),
    .pinSync (selSync)
  );

  pin_sync #(
    .RESET_LEVEL (`SYNC_RESET)
  ) clkSyncInst (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pinIn   (serialClk),
    .pinSync (clkSync)
  );

  pin_sync #(
    .RESET_LEVEL (`SYNC_RESET)
  ) dinSyncInst (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pinIn   (serial_in_line),
    .pinSync (dinSync)
  );

  // Edge registers start at the idle pin levels, so reset makes no false edge
  always @(posedge ref_clk) begin
    if (reset) begin
      selPrevReg <= `SEL_RESET;
      clkPrevReg <= `SYNC_RESET;
    end else begin
      selPrevReg <= selSync;
      clkPrevReg <= clkSync;
    end
  end

  // Receive side: clock counter saturates so long frames stay bad
  always @(posedge ref_clk) begin
    if (reset) begin
      countReg <= 5'h00;
    end else if (selFall) begin
      countReg <= 5'h00;
    end else if (clkFall & (countReg != `CNT_MAX)) begin
      countReg <= countReg + 5'h01;
    end
  end

  // Receive side: input shift register
  always @(posedge ref_clk) begin
    if (reset) begin
      inShiftReg <= 16'h0000;
    end else if (clkFall) begin
      inShiftReg <= {dinSync, inShiftReg[15:1]};
    end
  end

  // Output enable follows the synced select
  always @(posedge ref_clk) begin
    if (reset) begin
      serialOutEnable <= 1'b0;
    end else if (selRise) begin
      serialOutEnable <= 1'b0;
    end else if (selFall) begin
      serialOutEnable <= 1'b1;
    end
  end

  // Transmit side; output comes from the response word, with the fault flag ORed into bit 0, never the input
  always @(posedge ref_clk) begin
    if (reset) begin
      outShiftReg     <= 16'h0000;
      serial_out_line <= 1'b0;
    end else if (selRise) begin
      serial_out_line <= 1'b0;
    end else if (selFall) begin
      outShiftReg     <= {1'b0, responseWord[15:1]};
      serial_out_line <= responseWord[0] | faultReg;
    end else if (clkRise) begin
      serial_out_line <= outShiftReg[0];
      outShiftReg     <= {1'b0, outShiftReg[15:1]};
    end
  end

  // Fault flag: reported at the next select fall, set wins over that clear
  always @(posedge ref_clk) begin
    if (reset) begin
      faultReg <= `FAULT_RESET;
    end else if (selRise & frameBad & (countReg != 5'h00 | clkHighEdge | restartMode)) begin
      faultReg <= 1'b1;
    end else if (selRise & bufFull & (countReg != 5'h00)) begin
      faultReg <= 1'b1;
    end else if (selFall & clkHighEdge) begin
      faultReg <= 1'b1;
    end else if (selFall) begin
      faultReg <= 1'b0;
    end
  end

  // Two-entry frame buffer: storage needs no reset, fill count guards it
  always @(posedge ref_clk) begin
    if (bufPush) begin
      bufMem[wrPtrReg] <= inShiftReg;
    end
  end

  // Buffer pointers
  always @(posedge ref_clk) begin
    if (reset) begin
      wrPtrReg <= 1'b0;
      rdPtrReg <= 1'b0;
    end else begin
      if (bufPush) begin
        wrPtrReg <= ~wrPtrReg;
      end
      if (bufPop) begin
        rdPtrReg <= ~rdPtrReg;
      end
    end
  end

  // Buffer fill level; push never happens while full
  always @(posedge ref_clk) begin
    if (reset) begin
      fillReg <= 2'h0;
    end else if (bufPush & ~bufPop) begin
      fillReg <= fillReg + 2'h1;
    end else if (bufPop & ~bufPush) begin
      fillReg <= fillReg - 2'h1;
    end
  end

endmodule // spi_frame_slave

// Two flip-flop synchroniser for one asynchronous pin
module pin_sync #(
  parameter [0:0] RESET_LEVEL = 1'b0  // Level held during reset
) (
  input  wire ref_clk,  // System clock
  input  wire reset,    // Synchronous reset, active high
  input  wire pinIn,    // Asynchronous pin level
  output wire pinSync   // Level after two flip-flops
);

  // Stage one feeds stage two only; metastability settles there
  reg stage1Reg;
  reg stage2Reg;

  assign pinSync = stage2Reg;

  always @(posedge ref_clk) begin
    if (reset) begin
      stage1Reg <= RESET_LEVEL;
      stage2Reg <= RESET_LEVEL;
    end else begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
    end
  end

endmodule // pin_sync
`default_nettype wire

// ==== spi_frame_slave_checker.sv ====
// Purpose: port assertions. Assumes: slow serial pins. Notes: bound below.
`timescale 1ns/100ps
`default_nettype none
module spi_frame_slave_checker (
  input wire logic ref_clk,           // Clock
  input wire logic reset,             // Reset
  input wire logic select_active_low, // Select
  input wire logic serialClk,         // Link clock
  input wire logic serial_out_line,   // Data out
  input wire logic serialOutEnable,   // Out enable
  input wire logic restartMode,       // Restart
  input wire logic frameValid,        // Head valid
  input wire logic frameReady,        // Head taken
  input wire logic faultPending       // Fault
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_drive_fall: assert property ($fell(select_active_low) |-> ##[2:5] serialOutEnable) else $error("no drive");
  chk_release: assert property ($rose(select_active_low) |-> ##[2:5] !serialOutEnable) else $error("held");
  chk_idle_off: assert property (select_active_low [*8] |-> !serialOutEnable) else $error("idle drive");
  chk_late_use: assert property (!select_active_low [*6] |-> !$rose(frameValid)) else $error("early");
  chk_bit_hold: assert property ((!select_active_low && !serialClk) [*8] |-> $stable(serial_out_line))
    else $error("moved");
  chk_head_hold: assert property (frameValid && !frameReady |=> frameValid) else $error("head lost");
  chk_fault_hold: assert property (faultPending && select_active_low |=> faultPending) else $error("lost");
  chk_restart: assert property (restartMode [*8] |-> !$rose(frameValid)) else $error("restart frame");
  cover property ($rose(frameValid));
  cover property ($rose(faultPending));
  cover property (frameValid && frameReady);
endmodule // spi_frame_slave_checker
bind spi_frame_slave spi_frame_slave_checker chk (
  .ref_clk           (ref_clk),
  .reset             (reset),
  .select_active_low (select_active_low),
  .serialClk         (serialClk),
  .serial_out_line   (serial_out_line),
  .serialOutEnable   (serialOutEnable),
  .restartMode       (restartMode),
  .frameValid        (frameValid),
  .frameReady        (frameReady),
  .faultPending      (faultPending)
);
`default_nettype wire

// ==== spi_host_model.sv ====
// Purpose: host master. Assumes: clock idle low, 64 ns period. Notes: LSB first.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  output var logic select_active_low = 1'b1, // Select
  output var logic serialClk = 1'b0,         // Link clock
  output var logic serial_in_line = 1'b0,    // Data out
  input wire logic serial_out_line,          // Data in
  input wire logic serialOutEnable           // Slave drives
);
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
    #1 select_active_low = 1'b0;
    #64 rx[0] = serial_out_line & serialOutEnable;
    for (int i = 0; i < n; i++) begin
      serial_in_line = w[i];
      serialClk = 1'b1;
      #32 serialClk = 1'b0;
      #32 if (i < 15) rx[i + 1] = serial_out_line;
    end
    select_active_low = 1'b1;
    serial_in_line = ~serial_in_line; // Data line inverted at release, so no stale bit
    #160;
  endtask
  task automatic xfer_clk_high; // Clock held high across both select edges
    #1 serialClk = 1'b1;
    #32 select_active_low = 1'b0;
    #64 select_active_low = 1'b1;
    #32 serialClk = 1'b0;
    #160;
  endtask
endmodule // spi_host_model
`default_nettype wire

// ==== spi_frame_slave_bench.sv ====
// Purpose: frame bench. Assumes: host model drives pins. Notes: buffer drained late.
`timescale 1ns/100ps
`default_nettype none
module spi_frame_slave_bench;
  logic ref_clk = 1'b0, reset = 1'b1, restartMode = 1'b0, frameReady = 1'b0;
  logic [15:0] responseWord = 16'hA5C2, rx;
  wire logic select_active_low, serialClk, serial_in_line, serial_out_line, serialOutEnable;
  wire logic frameValid, frameWrite, faultPending;
  wire logic [6:0] frameAddr;
  wire logic [7:0] frameData;
  int num_errors = 0, total_checks = 0;
  spi_host_model host (
    .select_active_low (select_active_low),
    .serialClk         (serialClk),
    .serial_in_line    (serial_in_line),
    .serial_out_line   (serial_out_line),
    .serialOutEnable   (serialOutEnable)
  );
  spi_frame_slave DUT (
    .ref_clk           (ref_clk),
    .reset             (reset),
    .select_active_low (select_active_low),
    .serialClk         (serialClk),
    .serial_in_line    (serial_in_line),
    .serial_out_line   (serial_out_line),
    .serialOutEnable   (serialOutEnable),
    .restartMode       (restartMode),
    .responseWord      (responseWord),
    .frameValid        (frameValid),
    .frameReady        (frameReady),
    .frameAddr         (frameAddr),
    .frameWrite        (frameWrite),
    .frameData         (frameData),
    .faultPending      (faultPending)
  );
  initial forever #4 ref_clk = ~ref_clk;
  task automatic give_verdict;
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, got);
    total_checks++;
    if (got !== exp) $display("MISMATCH %s exp %h got %h", what, exp, got);
    if (got !== exp) num_errors++;
  endtask
  task automatic fill_drain; // Third frame meets a full buffer
    host.xfer(16'h9E35, 16, rx);
    cmp("reply", 16'hA5C2, rx);
    host.xfer(16'h41F2, 16, rx);
    host.xfer(16'h7777, 16, rx);
    cmp("head", 16'h9E35, {frameData, frameWrite, frameAddr});
    @(posedge ref_clk) frameReady <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk) cmp("next", 16'h41F2, {frameData, frameWrite, frameAddr});
    @(posedge ref_clk) frameReady <= 1'b0;
    host.xfer(16'h0000, 0, rx);
    cmp("quiet", 16'h0001, {13'h0, frameValid, faultPending, rx[0]});
  endtask
  task automatic clk_high_edges; // Clock high at both select edges
    host.xfer_clk_high();
    cmp("clkhigh", 16'h0001, {14'h0, frameValid, faultPending});
    host.xfer(16'h0000, 0, rx);
    cmp("clkflag", 16'h0001, {15'h0, rx[0]});
  endtask
  task automatic bad_frames; // Short count, then restart mode
    host.xfer(16'h1234, 5, rx);
    cmp("short", 16'h0001, {14'h0, frameValid, faultPending});
    @(posedge ref_clk) restartMode <= 1'b1;
    host.xfer(16'h5678, 16, rx);
    cmp("flagged", 16'hA5C3, rx);
    cmp("dropped", 16'h0001, {14'h0, frameValid, faultPending});
    @(posedge ref_clk) restartMode <= 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    #101 fill_drain();
    clk_high_edges();
    bad_frames();
    give_verdict();
  end
endmodule // spi_frame_slave_bench
`default_nettype wire
